// [core/phy_diag_status_regs.v]
// PHY diagnostic and status register bank with an AXI4-Lite slave
//
// Function
// R1 - Read-only partner pause bit at bit 10, resets to zero.
// R2 - Read-only partner abilities 100F,100H,10F,10H at bits 8 to 5, reset zero.
// R3 - Host writes enable bit one to start; device self-clears when test finishes.
// R4 - When enable reads zero, result, short flag and count are valid.
// R5 - Result codes: 00 normal, 01 open, 10 short, 11 test failed.
// R6 - Short flag set when the short lies nearer than ten meters.
// R7 - Nine-bit fault count; distance is about count times 0.4 meters.
// R8 - Polarity reversed status bit; meaningful only at 10BASE-T.
// R9 - Power saving control is active low and resets to one.
// R10 - Remote loopback bit returns line receive data to transmit via PHY.
// R11 - Host keeps reserved lowest special bit zero on writes.
// R12 - Reserved fields read zero; writes to them have no effect.
//
// Register map: byte addresses, one 16-bit register in the low half of each word
// 0x14 partner abilities, read only
// 0x74 cable test enable and results
// 0x7c line status and PHY controls
// 0x80 interrupt status, write one to clear
// 0x84 interrupt mask, a one lets its status bit through
//
// A cable test that never answers ends after DIAG_TIMEOUT cycles with the
// failed code, so software polling the enable bit always sees it clear.
`timescale 1ns/1ps
`include "phy_diag_defs.vh"
module phy_diag_status_regs
#(
    parameter DIAG_TIMEOUT = `DIAG_TIMEOUT_CYC
)
(
    input  wire        CLK,
    input  wire        NRST,
    // AXI4-Lite slave
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    // Auto-negotiation results from the PHY
    input  wire        LP_PAUSE,
    input  wire [3:0]  LP_ABILITY,
    // Line status from the PHY
    input  wire        POL_REVERSED,
    input  wire        MDI_MODE,
    // Cable test engine
    output wire        TDR_START,
    input  wire        TDR_DONE,
    input  wire [1:0]  TDR_RESULT,
    input  wire [8:0]  TDR_COUNT,
    // PHY controls
    output reg         FORCE_LINK,
    output reg         PWRSAVE_EN,
    output reg         REMOTE_LOOPBACK,
    output wire        IRQ
);

    // Write channel holding registers
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    // Sampled PHY status
    reg        lp_pause;
    reg [3:0]  lp_ability;
    reg        pol_reversed;
    reg        mdi_mode;
    reg        pwrsave_n;
    reg [1:0]  irq_status;
    reg [1:0]  irq_mask;
    wire [1:0] next_irq_status;
    wire [1:0] irq_event;
    wire [1:0] irq_clear;
    genvar     g;
    reg [31:0] rd_word;
    reg        rd_hit;
    reg        wr_hit;
    wire       diag_busy;
    wire       diag_done;
    wire [1:0] diag_result;
    wire       near_short_flag;
    wire [8:0] fault_count;
    wire       wr_fire;
    wire       lp_change;
    wire       diag_start;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel capture; address and data may arrive in either order
    // Both readies drop while a response waits, so one write at most is under way
    assign AWREADY = !aw_held && !BVALID;
    assign WREADY  = !w_held && !BVALID;
    assign wr_fire = aw_held && w_held && !BVALID;

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
            BVALID  <= 1'b0;
            BRESP   <= 2'h0;
        end
        else
        begin
            // Address half
            if (AWVALID && AWREADY)
            begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            // Data half
            if (WVALID && WREADY)
            begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            // Both halves held: perform the write and answer
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                BVALID  <= 1'b1;
                BRESP   <= wr_hit ? 2'h0 : 2'h2;   // Unmapped write gets SLVERR
            end
            else if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
            end
        end
    end

    // Write address decode
    always @*
    begin
        // R12 read-only targets decode as hits; their writes answer OKAY and are dropped
        case (aw_addr)
            `ADDR_LP_ABILITY: wr_hit = 1'b1;
            `ADDR_CABLE_DIAG: wr_hit = 1'b1;
            `ADDR_SPECIAL:    wr_hit = 1'b1;
            `ADDR_IRQ_STATUS: wr_hit = 1'b1;
            `ADDR_IRQ_MASK:   wr_hit = 1'b1;
            default:          wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status sampling from the PHY; inputs are synchronous to CLK
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            lp_pause     <= 1'b0;
            lp_ability   <= 4'h0;
            pol_reversed <= 1'b0;
            mdi_mode     <= 1'b0;
        end
        else
        begin
            // R1 partner pause
            lp_pause     <= LP_PAUSE;
            // R2 partner abilities
            lp_ability   <= LP_ABILITY;
            // R8 polarity status
            pol_reversed <= POL_REVERSED;
            // MDI or crossover state of the line pair
            mdi_mode     <= MDI_MODE;
        end
    end

    // Partner ability change: input differs from last cycle's sample
    assign lp_change = (LP_PAUSE != lp_pause) || (LP_ABILITY != lp_ability);

    ////////////////////////////////////////////////////////////////////////////
    // Special control bits; low byte lane carries all of them
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            FORCE_LINK      <= `FORCE_RESET;
            pwrsave_n       <= `PWRSAVE_RESET;
            REMOTE_LOOPBACK <= `LOOPBACK_RESET;
        end
        // R12 only bits 3 to 1 are stored; the rest of the word is dropped
        else if (wr_fire && aw_addr == `ADDR_SPECIAL && w_strb[0])
        begin
            // Force link pass, for bring-up without a partner
            FORCE_LINK      <= w_data[`SPEC_FORCE_BIT];
            // R9 active low power save
            pwrsave_n       <= w_data[`SPEC_PWRSAVE_BIT];
            // R10 loopback control
            REMOTE_LOOPBACK <= w_data[`SPEC_LOOPBACK_BIT];
            // R11 reserved bit zero is not stored, so a stray one does no harm
        end
    end

    // R9 inverted enable
    always @*
    begin
        PWRSAVE_EN = !pwrsave_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // R3 start on write of one; ignored while a test already runs
    assign diag_start = wr_fire && aw_addr == `ADDR_CABLE_DIAG && w_strb[1] &&
                        w_data[`DIAG_ENABLE_BIT] && !diag_busy;

    // Sequencer owns the busy bit, the results and the one-cycle start pulse
    cable_diag_seq #(
        .TIMEOUT_CYC (DIAG_TIMEOUT)
    ) u_seq (
        .clk             (CLK),
        .nrst            (NRST),
        .start           (diag_start),
        .tdr_done        (TDR_DONE),
        .tdr_result      (TDR_RESULT),
        .tdr_count       (TDR_COUNT),
        .busy            (diag_busy),
        .tdr_start       (TDR_START),
        .done_pulse      (diag_done),
        .result          (diag_result),
        .near_short_flag (near_short_flag),
        .fault_count     (fault_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Events that set the sticky status bits
    assign irq_event[`IRQ_DIAG_DONE] = diag_done;
    assign irq_event[`IRQ_LP_CHANGE] = lp_change;

    // Write-one-to-clear mask; only the low byte lane reaches the status bits
    assign irq_clear = (wr_fire && aw_addr == `ADDR_IRQ_STATUS && w_strb[0]) ?
                       w_data[1:0] : 2'h0;

    // Interrupt status per bit: an event in the cycle of its clear wins,
    // so software can never wipe an event it has not yet seen
    generate
        for (g = 0; g < `IRQ_WIDTH; g = g + 1)
        begin : g_irq
            assign next_irq_status[g] = irq_event[g] | (irq_status[g] & ~irq_clear[g]);
        end
    endgenerate

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_fire && aw_addr == `ADDR_IRQ_MASK && w_strb[0])
                irq_mask <= w_data[1:0];
        end
    end

    // Level output; a mask bit of one lets its status through
    assign IRQ = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; R12 reserved bits are zero-filled here
    always @*
    begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (ARADDR)
            // Partner abilities learned by auto-negotiation
            `ADDR_LP_ABILITY:
            begin
                rd_word[`LP_PAUSE_BIT]              = lp_pause;
                rd_word[`LP_ABIL_HI:`LP_ABIL_LO]    = lp_ability;
            end
            `ADDR_CABLE_DIAG:
            begin
                // R3 enable bit reads busy, so it self-clears
                // R4 enable clears with results
                rd_word[`DIAG_ENABLE_BIT]                  = diag_busy;
                rd_word[`DIAG_RESULT_HI:`DIAG_RESULT_LO]   = diag_result;
                rd_word[`DIAG_SHORT_BIT]                   = near_short_flag;
                rd_word[`DIAG_COUNT_HI:`DIAG_COUNT_LO]     = fault_count;
            end
            // Line status and PHY controls
            `ADDR_SPECIAL:
            begin
                rd_word[`SPEC_POL_BIT]      = pol_reversed;
                rd_word[`SPEC_MDI_BIT]      = mdi_mode;
                rd_word[`SPEC_FORCE_BIT]    = FORCE_LINK;
                rd_word[`SPEC_PWRSAVE_BIT]  = pwrsave_n;
                rd_word[`SPEC_LOOPBACK_BIT] = REMOTE_LOOPBACK;
            end
            // Interrupt bits
            `ADDR_IRQ_STATUS: rd_word[1:0] = irq_status;
            `ADDR_IRQ_MASK:   rd_word[1:0] = irq_mask;
            default:          rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle to answer, held until RREADY
    assign ARREADY = !RVALID;

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0;
            RRESP  <= 2'h0;
        end
        else if (ARVALID && ARREADY)
        begin
            // Word is captured in the accepting cycle so RDATA stands still
            RVALID <= 1'b1;
            RDATA  <= rd_word;
            RRESP  <= rd_hit ? 2'h0 : 2'h2;   // Unmapped read gets SLVERR
        end
        else if (RVALID && RREADY)
        begin
            // Answer taken; the next address may follow at once
            RVALID <= 1'b0;
        end
    end

endmodule // phy_diag_status_regs

// [core/phy_diag_defs.vh]
// Register offsets, field positions, reset values and timing counts for the PHY diagnostic view
`ifndef PHY_DIAG_DEFS_VH
`define PHY_DIAG_DEFS_VH

// Register offsets (byte addresses = index * 4)
`define IDX_LP_ABILITY      8'h05
`define IDX_CABLE_DIAG      8'h1d
`define IDX_SPECIAL         8'h1f
`define IDX_IRQ_STATUS      8'h20
`define IDX_IRQ_MASK        8'h21
`define ADDR_LP_ABILITY     8'h14
`define ADDR_CABLE_DIAG     8'h74
`define ADDR_SPECIAL        8'h7c
`define ADDR_IRQ_STATUS     8'h80
`define ADDR_IRQ_MASK       8'h84

// Link partner ability fields
`define LP_PAUSE_BIT        10
`define LP_ABIL_HI          8
`define LP_ABIL_LO          5

// Cable diagnostic fields
`define DIAG_ENABLE_BIT     15
`define DIAG_RESULT_HI      14
`define DIAG_RESULT_LO      13
`define DIAG_SHORT_BIT      12
`define DIAG_COUNT_HI       8
`define DIAG_COUNT_LO       0

// Diagnostic result codes
`define RESULT_NORMAL       2'h0
`define RESULT_OPEN         2'h1
`define RESULT_SHORT        2'h2
`define RESULT_FAILED       2'h3

// Special control/status fields
`define SPEC_POL_BIT        5
`define SPEC_MDI_BIT        4
`define SPEC_FORCE_BIT      3
`define SPEC_PWRSAVE_BIT    2
`define SPEC_LOOPBACK_BIT   1

// Reset values
`define PWRSAVE_RESET       1'h1
`define FORCE_RESET         1'h0
`define LOOPBACK_RESET      1'h0

// Interrupt status bits
`define IRQ_DIAG_DONE       0
`define IRQ_LP_CHANGE       1
`define IRQ_WIDTH           2

// Diagnostic timeout: 100 us at 10 ns per cycle, a least time rounded up
`define DIAG_TIMEOUT_US     100
`define CLK_PERIOD_NS       10
`define DIAG_TIMEOUT_CYC    ((`DIAG_TIMEOUT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Short-distance limit: 10 m in steps of 0.4 m is 25 counts
`define SHORT_LIMIT_COUNT   9'h019

`endif

// [core/cable_diag_seq.v]
// Cable diagnostic sequencer: runs one test, captures and holds its results
`timescale 1ns/1ps
`include "phy_diag_defs.vh"
module cable_diag_seq
#(
    parameter TIMEOUT_CYC = `DIAG_TIMEOUT_CYC
)
(
    input  wire       clk,
    input  wire       nrst,
    input  wire       start,
    input  wire       tdr_done,
    input  wire [1:0] tdr_result,
    input  wire [8:0] tdr_count,
    output reg        busy,
    output reg        tdr_start,
    output reg        done_pulse,
    output reg  [1:0] result,
    output reg        near_short_flag,
    output reg  [8:0] fault_count
);

    localparam IDLE = 1'b0;
    localparam RUN  = 1'b1;

    reg        state;
    reg [31:0] timer;

    ////////////////////////////////////////////////////////////////////////////
    // Test sequence; timeout guards against an analog engine that never answers
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state           <= IDLE;
            timer           <= 32'h0;
            busy            <= 1'b0;
            tdr_start       <= 1'b0;
            done_pulse      <= 1'b0;
            result          <= `RESULT_NORMAL;
            near_short_flag <= 1'b0;
            fault_count     <= 9'h000;
        end
        else
        begin
            tdr_start  <= 1'b0;
            done_pulse <= 1'b0;
            case (state)
                IDLE:
                begin
                    if (start)
                    begin
                        state     <= RUN;
                        busy      <= 1'b1;
                        tdr_start <= 1'b1;
                        timer     <= 32'h0;
                    end
                end
                RUN:
                begin
                    timer <= timer + 32'h1;
                    // R4 results with clear
                    if (tdr_done)
                    begin
                        state       <= IDLE;
                        busy        <= 1'b0;
                        done_pulse  <= 1'b1;
                        // R5 result encoding
                        result      <= tdr_result;
                        // R7 fault distance
                        fault_count <= tdr_count;
                        // R6 near short
                        near_short_flag <= (tdr_result == `RESULT_SHORT) &&
                                           (tdr_count < `SHORT_LIMIT_COUNT);
                    end
                    else if (timer >= TIMEOUT_CYC - 1)
                    begin
                        // R5 failed test code
                        state           <= IDLE;
                        busy            <= 1'b0;
                        done_pulse      <= 1'b1;
                        result          <= `RESULT_FAILED;
                        near_short_flag <= 1'b0;
                        fault_count     <= 9'h000;
                    end
                end
                default:
                begin
                    state <= IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

endmodule // cable_diag_seq

// [test/phy_diag_status_regs_assertions.sv]
// Checker for bus handshakes and the cable test start pulse of the register bank
`timescale 1ns/1ps
module phy_diag_status_regs_assertions
(
    input wire        CLK,
    input wire        NRST,
    input wire        AWVALID,
    input wire        AWREADY,
    input wire        WVALID,
    input wire        WREADY,
    input wire [1:0]  BRESP,
    input wire        BVALID,
    input wire        BREADY,
    input wire        ARVALID,
    input wire        ARREADY,
    input wire [31:0] RDATA,
    input wire [1:0]  RRESP,
    input wire        RVALID,
    input wire        RREADY,
    input wire        TDR_START
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////////
    // Answers stand until taken, so a slow host never loses one
    a_b_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    a_aw_block: assert property (BVALID |-> !AWREADY && !WREADY)
        else $error("write accepted while response pending");
    a_ar_block: assert property (RVALID |-> !ARREADY)
        else $error("read accepted while data pending");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response late");
    a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
        else $error("read data late");
    a_resp_code: assert property (BVALID || RVALID |-> !BRESP[0] && !RRESP[0])
        else $error("illegal response code");
    a_read_upper: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_start_pulse: assert property (TDR_START |=> !TDR_START)
        else $error("test start longer than one cycle");
    a_start_cause: assert property (TDR_START |-> $rose(BVALID))
        else $error("test start without a write");
endmodule // phy_diag_status_regs_assertions
bind phy_diag_status_regs phy_diag_status_regs_assertions i_chk (.*);

// [test/cable_test_model.sv]
// Behavioural cable test engine answering each start made while mute is low after a fixed delay
`timescale 1ns/1ps
module cable_test_model
#(
    parameter delay = 20
)
(
    input  wire       clk,
    input  wire       nrst,
    input  wire       start,
    input  wire       mute,
    input  wire [1:0] res,
    input  wire [8:0] cnt,
    output reg        done,
    output reg  [1:0] result,
    output reg  [8:0] count
);
    integer n;
    ////////////////////////////////////////////////////////////////////////////////
    // Outside the done pulse the lines toggle, so stale values are never trusted
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            n      <= 0;
            done   <= 1'h0;
            result <= 2'h0;
            count  <= 9'h000;
        end
        else
        begin
            done   <= 1'h0;
            result <= ~result;
            count  <= ~count;
            if (start && !mute)
                n <= delay;
            else if (n == 1)
            begin
                done   <= 1'h1;
                result <= res;
                count  <= cnt;
                n      <= 0;
            end
            else if (n > 1)
                n <= n - 1;
        end
    end
endmodule // cable_test_model

// [test/phy_diag_status_regs_tb.sv]
// Testbench for the PHY diagnostic register bank
`timescale 1ns/1ps
module phy_diag_status_regs_tb;
    reg         CLK = 1'h0, NRST = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
    reg         ARVALID = 1'h0, RREADY = 1'h0, LP_PAUSE = 1'h0, POL_REVERSED = 1'h0;
    reg         MDI_MODE = 1'h0, mute = 1'h0;
    reg  [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    reg  [31:0] WDATA = 32'h0;
    reg  [3:0]  WSTRB = 4'h0, LP_ABILITY = 4'h0;
    reg  [1:0]  res = 2'h0, r;
    reg  [8:0]  cnt = 9'h000;
    reg  [31:0] v;
    wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, TDR_START, TDR_DONE, IRQ;
    wire        FORCE_LINK, PWRSAVE_EN, REMOTE_LOOPBACK;
    wire [1:0]  BRESP, RRESP, TDR_RESULT;
    wire [8:0]  TDR_COUNT;
    wire [31:0] RDATA;
    integer     bad_count = 0, n_tests = 0, i;

    always #5 CLK = ~CLK;

    phy_diag_status_regs #(.DIAG_TIMEOUT(50)) i_dut (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
        .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .LP_PAUSE(LP_PAUSE), .LP_ABILITY(LP_ABILITY),
        .POL_REVERSED(POL_REVERSED), .MDI_MODE(MDI_MODE), .TDR_START(TDR_START),
        .TDR_DONE(TDR_DONE), .TDR_RESULT(TDR_RESULT), .TDR_COUNT(TDR_COUNT),
        .FORCE_LINK(FORCE_LINK), .PWRSAVE_EN(PWRSAVE_EN), .REMOTE_LOOPBACK(REMOTE_LOOPBACK),
        .IRQ(IRQ));
    cable_test_model #(.delay(20)) i_eng (.clk(CLK), .nrst(NRST), .start(TDR_START),
        .mute(mute), .res(res), .cnt(cnt), .done(TDR_DONE), .result(TDR_RESULT),
        .count(TDR_COUNT));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task chk(input [31:0] g, input [31:0] e);
    begin
        n_tests = n_tests + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task results;
    begin
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Bus master: address and data offered together, each released when taken
    task wr(input [7:0] a, input [31:0] d, output [1:0] rs);
    begin
        @(posedge CLK);
        AWADDR <= a; WDATA <= d; WSTRB <= 4'hf; AWVALID <= 1'h1; WVALID <= 1'h1; BREADY <= 1'h1;
        do
        begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'h0;
            if (WREADY) WVALID <= 1'h0;
        end
        while (BVALID !== 1'h1);
        rs = BRESP;
        BREADY <= 1'h0;
    end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] rs);
    begin
        @(posedge CLK);
        ARADDR <= a; ARVALID <= 1'h1; RREADY <= 1'h1;
        do
        begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'h0;
        end
        while (RVALID !== 1'h1);
        d = RDATA; rs = RRESP;
        RREADY <= 1'h0;
    end
    endtask
    // Start a test, see it busy, poll until the enable bit self-clears
    task run_test(input [1:0] rr, input [8:0] cc, input [31:0] e);
    begin
        res <= rr; cnt <= cc;
        wr(8'h74, 32'h8000, r);
        chk(r, 2'h0);
        rd(8'h74, v, r);
        chk(v[15], 1'h1);
        i = 0;
        while (v[15] === 1'h1 && i < 40)
        begin
            rd(8'h74, v, r);
            i = i + 1;
        end
        chk(v, e);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (16) @(posedge CLK);
        NRST <= 1'h1;
        @(posedge CLK);
        chk({PWRSAVE_EN, FORCE_LINK, REMOTE_LOOPBACK, IRQ}, 4'h0);
        rd(8'h14, v, r); chk(v, 32'h0);
        rd(8'h74, v, r); chk(v, 32'h0);
        rd(8'h7c, v, r); chk(v, 32'h4);
        LP_PAUSE <= 1'h1; LP_ABILITY <= 4'ha; POL_REVERSED <= 1'h1; MDI_MODE <= 1'h1;
        wr(8'h14, 32'hffffffff, r);
        rd(8'h14, v, r); chk(v, 32'h540);
        wr(8'h7c, 32'hfffe, r);
        rd(8'h7c, v, r); chk(v, 32'h3e);
        chk({PWRSAVE_EN, FORCE_LINK, REMOTE_LOOPBACK}, 3'h3);
        wr(8'h7c, 32'h0, r);
        rd(8'h7c, v, r); chk(v, 32'h30);
        chk({PWRSAVE_EN, FORCE_LINK, REMOTE_LOOPBACK}, 3'h4);
        rd(8'h80, v, r); chk(v, 32'h2); chk(r, 2'h0);
        chk(IRQ, 1'h0);
        wr(8'h80, 32'h3, r); wr(8'h84, 32'h1, r);
        run_test(2'h0, 9'h064, 32'h0064);
        run_test(2'h1, 9'h12c, 32'h212c);
        run_test(2'h2, 9'h018, 32'h5018);
        run_test(2'h2, 9'h019, 32'h4019);
        run_test(2'h3, 9'h1ff, 32'h61ff);
        chk(IRQ, 1'h1);
        rd(8'h80, v, r); chk(v, 32'h1);
        wr(8'h80, 32'h1, r); chk(IRQ, 1'h0);
        // Silent engine: the test must end on its own with a failure code
        wr(8'h84, 32'h0, r);
        mute <= 1'h1;
        run_test(2'h0, 9'h000, 32'h6000);
        chk(IRQ, 1'h0);
        rd(8'h80, v, r); chk(v, 32'h1);
        mute <= 1'h0;
        wr(8'h40, 32'h1, r); chk(r, 2'h2);
        rd(8'h40, v, r); chk(r, 2'h2);
        results;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #300000;
        bad_count = bad_count + 1;
        results;
    end
endmodule // phy_diag_status_regs_tb
